// ### pkg/slm_consts.vh
// constants for the sleep entry and literal subtract execution block
`ifndef SLM_CONSTS_VH
`define SLM_CONSTS_VH
// register byte offsets on the axi4-lite bus
`define SLM_OFF_CTRL 5'h00
`define SLM_OFF_INSTR 5'h04
`define SLM_OFF_ACC 5'h08
`define SLM_OFF_STATUS 5'h0c
`define SLM_OFF_IRQ_STAT 5'h10
`define SLM_OFF_IRQ_MASK 5'h14
`define SLM_OFF_WDOG 5'h18
// instruction encodings (14 bits)
`define SLM_OP_SLEEP 14'h0063
`define SLM_OP_LMA_HI 5'h1e
// status field positions
`define SLM_ST_CARRY 0
`define SLM_ST_DC 1
`define SLM_ST_ZERO 2
`define SLM_ST_PD 3
`define SLM_ST_TO 4
`define SLM_ST_ASLEEP 5
// irq bits
`define SLM_IRQ_SLEEP 0
`define SLM_IRQ_LMA 1
// reset values
`define SLM_RST_PD 1'b1
`define SLM_RST_TO 1'b1
`define SLM_RST_ACC 8'h00
`define SLM_WDOG_CLEAR 8'h00
`endif

// ### hw/slm_subtract.v
// literal minus accumulator arithmetic with carry, digit carry and zero
`timescale 1ns/1ps
`default_nettype none
module slm_subtract (
  input wire [7:0] literal,
  input wire [7:0] acc,
  output wire [7:0] result,
  output wire carry,
  output wire digit_carry,
  output wire zero
);
  wire [8:0] full_sum;
  wire [4:0] low_sum;
  // two's complement: k + ~w + 1, carry out means no borrow
  assign full_sum = {1'b0, literal} + {1'b0, ~acc} + 9'h001;
  assign low_sum = {1'b0, literal[3:0]} + {1'b0, ~acc[3:0]} + 5'h01;
  assign result = full_sum[7:0];
  assign carry = full_sum[8];
  assign digit_carry = low_sum[4];
  assign zero = (full_sum[7:0] == 8'h00);
endmodule // slm_subtract
`default_nettype wire

// ### hw/slm_sticky.v
// one sticky event bit, set wins over write-one clear
`timescale 1ns/1ps
`default_nettype none
module slm_sticky (
  input wire aclk,
  input wire aresetn,
  input wire set,
  input wire clr,
  output reg flag_q
);
  // hold until cleared, a set in the clear cycle survives
  always @(posedge aclk) begin
    if (!aresetn) begin
      flag_q <= 1'b0;
    end else if (set) begin
      flag_q <= 1'b1;
    end else if (clr) begin
      flag_q <= 1'b0;
    end
  end
endmodule // slm_sticky
`default_nettype wire

// ### hw/slm_core_exec.v
// sleep entry and literal subtract execution with axi4-lite registers
// Functional notes
// - halt instruction clears the power-down flag to zero
// - halt instruction sets the time-out flag to one
// - halt instruction clears watchdog counter and its prescaler
// - after halt, oscillator stops and fetch halts until wake-up
`timescale 1ns/1ps
`default_nettype none
`include "slm_consts.vh"
module slm_core_exec (
  input wire aclk,
  input wire aresetn,
  input wire [4:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [4:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire wake_pin,
  output reg osc_run_q,
  output reg fetch_enable_q,
  output reg watchdog_clear_q,
  output reg [7:0] watchdog_counter_q,
  output reg [7:0] prescaler_q,
  output wire irq
);
  // one-hot core states
  localparam [1:0] ST_RUN = 2'b01;
  localparam [1:0] ST_SLEEP = 2'b10;
  reg [1:0] state_q;
  reg [7:0] acc_q;
  reg carry_q;
  reg digit_carry_q;
  reg zero_q;
  reg power_down_flag_q;
  reg timeout_flag_q;
  reg [1:0] irq_mask_q;
  wire [1:0] irq_stat;
  // bus write capture
  reg [4:0] awaddr_q;
  reg aw_have_q;
  reg [31:0] wdata_q;
  reg [3:0] wstrb_q;
  reg w_have_q;
  wire wr_fire;
  reg wr_addr_ok;
  // instruction issue
  reg issue_q;
  reg [13:0] instr_q;
  wire do_sleep;
  wire do_lma;
  wire [7:0] lma_result;
  wire lma_carry;
  wire lma_dc;
  wire lma_zero;
  // wake pin synchroniser
  reg wake_meta_q;
  reg wake_sync_q;
  wire [1:0] irq_set;
  wire [1:0] irq_clr;
  wire [7:0] status_word;

  assign s_axi_awready = !aw_have_q && !s_axi_bvalid;
  assign s_axi_wready = !w_have_q && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign wr_fire = aw_have_q && w_have_q && !s_axi_bvalid;

  // capture address and data independently, in either order
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      awaddr_q <= 5'h00;
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end else if (wr_fire) begin
        aw_have_q <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end else if (wr_fire) begin
        w_have_q <= 1'b0;
      end
    end
  end

  // write address decode, unlisted or unaligned offsets answer slverr
  always @* begin
    case (awaddr_q)
      `SLM_OFF_CTRL, `SLM_OFF_INSTR, `SLM_OFF_ACC, `SLM_OFF_STATUS,
      `SLM_OFF_IRQ_STAT, `SLM_OFF_IRQ_MASK, `SLM_OFF_WDOG: begin
        wr_addr_ok = 1'b1;
      end
      default: begin
        wr_addr_ok = 1'b0;
      end
    endcase
  end

  // write response, slverr for unmapped addresses
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_addr_ok ? 2'b00 : 2'b10;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // instruction register write with both low strobes in the run state issues one execution pulse
  always @(posedge aclk) begin
    if (!aresetn) begin
      issue_q <= 1'b0;
      instr_q <= 14'h0000;
    end else begin
      issue_q <= wr_fire && (awaddr_q == `SLM_OFF_INSTR) &&
                 wstrb_q[0] && wstrb_q[1] && (state_q == ST_RUN);
      if (wr_fire && (awaddr_q == `SLM_OFF_INSTR)) begin
        instr_q <= wdata_q[13:0];
      end
    end
  end

  assign do_sleep = issue_q && (instr_q == `SLM_OP_SLEEP);
  assign do_lma = issue_q && (instr_q[13:9] == `SLM_OP_LMA_HI);

  slm_subtract u_sub (
    .literal(instr_q[7:0]),
    .acc(acc_q),
    .result(lma_result),
    .carry(lma_carry),
    .digit_carry(lma_dc),
    .zero(lma_zero)
  );

  // wake pin passes two flops before use
  always @(posedge aclk) begin
    if (!aresetn) begin
      wake_meta_q <= 1'b0;
      wake_sync_q <= 1'b0;
    end else begin
      wake_meta_q <= wake_pin;
      wake_sync_q <= wake_meta_q;
    end
  end

  // run and sleep states
  always @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= ST_RUN;
      osc_run_q <= 1'b1;
      fetch_enable_q <= 1'b1;
    end else begin
      case (state_q)
        ST_RUN: begin
          if (do_sleep) begin
            state_q <= ST_SLEEP;
            osc_run_q <= 1'b0;
            fetch_enable_q <= 1'b0;
          end
        end
        ST_SLEEP: begin
          if (wake_sync_q) begin
            state_q <= ST_RUN;
            osc_run_q <= 1'b1;
            fetch_enable_q <= 1'b1;
          end
        end
        default: begin
          state_q <= ST_RUN;
          osc_run_q <= 1'b1;
          fetch_enable_q <= 1'b1;
        end
      endcase
    end
  end

  // status flags and watchdog clear
  always @(posedge aclk) begin
    if (!aresetn) begin
      power_down_flag_q <= `SLM_RST_PD;
      timeout_flag_q <= `SLM_RST_TO;
      watchdog_counter_q <= `SLM_WDOG_CLEAR;
      prescaler_q <= `SLM_WDOG_CLEAR;
      watchdog_clear_q <= 1'b0;
    end else begin
      watchdog_clear_q <= do_sleep;
      if (do_sleep) begin
        power_down_flag_q <= 1'b0;
        timeout_flag_q <= 1'b1;
        watchdog_counter_q <= `SLM_WDOG_CLEAR;
        prescaler_q <= `SLM_WDOG_CLEAR;
      end else if (wr_fire && awaddr_q == `SLM_OFF_WDOG && wstrb_q[0]) begin
        watchdog_counter_q <= wdata_q[7:0];
        prescaler_q <= wdata_q[15:8];
      end
    end
  end

  // accumulator and arithmetic flags
  always @(posedge aclk) begin
    if (!aresetn) begin
      acc_q <= `SLM_RST_ACC;
      carry_q <= 1'b0;
      digit_carry_q <= 1'b0;
      zero_q <= 1'b0;
    end else if (do_lma) begin
      acc_q <= lma_result;
      carry_q <= lma_carry;
      digit_carry_q <= lma_dc;
      zero_q <= lma_zero;
    end else if (wr_fire && awaddr_q == `SLM_OFF_ACC && wstrb_q[0]) begin
      acc_q <= wdata_q[7:0];
    end
  end

  // sticky interrupt status, write one to clear
  assign irq_set[`SLM_IRQ_SLEEP] = do_sleep;
  assign irq_set[`SLM_IRQ_LMA] = do_lma;
  assign irq_clr = (wr_fire && awaddr_q == `SLM_OFF_IRQ_STAT && wstrb_q[0]) ?
                   wdata_q[1:0] : 2'b00;

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_irq
      slm_sticky u_bit (
        .aclk(aclk),
        .aresetn(aresetn),
        .set(irq_set[gi]),
        .clr(irq_clr[gi]),
        .flag_q(irq_stat[gi])
      );
    end
  endgenerate

  // mask register
  always @(posedge aclk) begin
    if (!aresetn) begin
      irq_mask_q <= 2'b00;
    end else if (wr_fire && awaddr_q == `SLM_OFF_IRQ_MASK && wstrb_q[0]) begin
      irq_mask_q <= wdata_q[1:0];
    end
  end

  assign irq = |(irq_stat & irq_mask_q);

  // status word built from the field positions
  assign status_word[`SLM_ST_CARRY] = carry_q;
  assign status_word[`SLM_ST_DC] = digit_carry_q;
  assign status_word[`SLM_ST_ZERO] = zero_q;
  assign status_word[`SLM_ST_PD] = power_down_flag_q;
  assign status_word[`SLM_ST_TO] = timeout_flag_q;
  assign status_word[`SLM_ST_ASLEEP] = (state_q == ST_SLEEP);
  assign status_word[7:6] = 2'b00;

  // read channel, one cycle after the address is taken
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= 2'b00;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= 2'b00;
      case (s_axi_araddr)
        `SLM_OFF_CTRL: s_axi_rdata <= {30'h0, fetch_enable_q, osc_run_q};
        `SLM_OFF_INSTR: s_axi_rdata <= {18'h0, instr_q};
        `SLM_OFF_ACC: s_axi_rdata <= {24'h0, acc_q};
        `SLM_OFF_STATUS: s_axi_rdata <= {24'h0, status_word};
        `SLM_OFF_IRQ_STAT: s_axi_rdata <= {30'h0, irq_stat};
        `SLM_OFF_IRQ_MASK: s_axi_rdata <= {30'h0, irq_mask_q};
        `SLM_OFF_WDOG: s_axi_rdata <= {16'h0, prescaler_q,
                                       watchdog_counter_q};
        default: begin
          s_axi_rdata <= 32'h00000000;
          s_axi_rresp <= 2'b10;
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule // slm_core_exec
`default_nettype wire

// ### verif/slm_core_exec_sva.sv
// assertion checker for the execution block ports
`timescale 1ns/1ps
`default_nettype none
module slm_core_exec_sva (
  input wire aclk,
  input wire aresetn,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire osc_run_q,
  input wire fetch_enable_q,
  input wire watchdog_clear_q,
  input wire [7:0] watchdog_counter_q,
  input wire [7:0] prescaler_q
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // halt clears the watchdog and stops the core
  wdog_zero_a: assert property (watchdog_clear_q |->
    watchdog_counter_q == 8'h00 && prescaler_q == 8'h00)
    else $error("watchdog not cleared by halt");
  clear_pulse_a: assert property (watchdog_clear_q |=> !watchdog_clear_q)
    else $error("watchdog clear longer than one cycle");
  halt_stop_a: assert property (watchdog_clear_q |->
    !osc_run_q && !fetch_enable_q)
    else $error("core still running after halt");
  osc_cause_a: assert property ($fell(osc_run_q) |-> watchdog_clear_q)
    else $error("oscillator stopped without halt");
  fetch_osc_a: assert property (fetch_enable_q |-> osc_run_q)
    else $error("fetch enabled with oscillator stopped");
  bvalid_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid) else $error("write response dropped early");
  rvalid_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid) else $error("read response dropped early");
  // main scenarios
  halt_c: cover property (watchdog_clear_q);
  wake_c: cover property ($rose(osc_run_q));
  read_c: cover property (s_axi_rvalid && s_axi_rready);
endmodule // slm_core_exec_sva
bind slm_core_exec slm_core_exec_sva u_sva (.aclk(aclk), .aresetn(aresetn),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .osc_run_q(osc_run_q), .fetch_enable_q(fetch_enable_q),
  .watchdog_clear_q(watchdog_clear_q),
  .watchdog_counter_q(watchdog_counter_q), .prescaler_q(prescaler_q));
`default_nettype wire

// ### verif/sleep_entry_and_literal_subtract_tb_top.sv
// self-checking bench for the execution block
`timescale 1ns/1ps
`default_nettype none
`include "slm_consts.vh"
`define CHK(n, e, s) begin n_tests++; if ((s) !== (e)) begin bad_count++; \
  $display("BAD %s exp %h got %h", n, e, s); end end
module sleep_entry_and_literal_subtract_tb_top;
  logic aclk = 0, aresetn = 0, wake_pin = 0;
  logic [4:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rd;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  wire awready, wready, bvalid, arready, rvalid, osc, fetch, wclr, irq;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire [7:0] wcnt, pres;
  int bad_count = 0, n_tests = 0;
  logic [10:0] exp;
  logic [1:0] rs, bs;
  logic [7:0] k, w;
  slm_core_exec uut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .wake_pin(wake_pin),
    .osc_run_q(osc), .fetch_enable_q(fetch), .watchdog_clear_q(wclr),
    .watchdog_counter_q(wcnt), .prescaler_q(pres), .irq(irq));
  // clock
  initial forever #5 aclk = ~aclk;
  // flags expected from literal minus accumulator
  function automatic logic [10:0] lma(input logic [7:0] k, input logic [7:0] w);
    logic [7:0] r;
    r = k - w;
    return {r == 8'h00, k[3:0] >= w[3:0], k >= w, r};
  endfunction
  // one write, address and data offered together
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    logic ao, wo, b;
    b = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    while (!b) begin
      @(negedge aclk);
      ao = awvalid && awready;
      wo = wvalid && wready;
      b = bvalid;
      bs = bresp;
      @(posedge aclk);
      if (ao) awvalid <= 0;
      if (wo) wvalid <= 0;
      if (b) bready <= 0;
    end
  endtask
  // one read, data and response kept in rd and rs
  task automatic rdr(input logic [4:0] a);
    logic ao, r;
    r = 0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    while (!r) begin
      @(negedge aclk);
      ao = arvalid && arready;
      r = rvalid;
      rd = rdata;
      rs = rresp;
      @(posedge aclk);
      if (ao) arvalid <= 0;
      if (r) rready <= 0;
    end
  endtask
  // verdict and end of run
  task automatic give_verdict();
    $display("tests %0d bad %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // hang guard
  initial begin
    #200000;
    bad_count++;
    give_verdict();
  end
  // main sequence
  initial begin
    void'($urandom(70));
    repeat (3) @(posedge aclk);
    aresetn <= 1;
    rdr(`SLM_OFF_STATUS);
    `CHK("status rst", 6'h18, rd[5:0])
    rdr(`SLM_OFF_CTRL);
    `CHK("ctrl rst", 2'h3, rd[1:0])
    wr(`SLM_OFF_IRQ_MASK, 32'h0);
    for (int i = 0; i < 24; i++) begin
      k = (i < 3) ? 8'h02 : 8'($urandom);
      w = (i < 3) ? 8'(i + 1) : 8'($urandom);
      exp = lma(k, w);
      wr(`SLM_OFF_ACC, {24'h0, w});
      wr(`SLM_OFF_INSTR, {18'h0, 5'h1e, 1'(i), k});
      rdr(`SLM_OFF_ACC);
      `CHK("acc", exp[7:0], rd[7:0])
      rdr(`SLM_OFF_STATUS);
      `CHK("flags", exp[10:8], rd[2:0])
    end
    @(negedge aclk);
    `CHK("irq masked", 1'h0, irq)
    wr(`SLM_OFF_IRQ_MASK, 32'h2);
    @(negedge aclk);
    `CHK("irq on", 1'h1, irq)
    wr(`SLM_OFF_IRQ_STAT, 32'h3);
    @(negedge aclk);
    `CHK("irq clr", 1'h0, irq)
    wr(`SLM_OFF_WDOG, 32'h5a3c);
    `CHK("bresp ok", 2'h0, bs)
    rdr(`SLM_OFF_WDOG);
    `CHK("wdog rw", 16'h5a3c, rd[15:0])
    wr(`SLM_OFF_IRQ_MASK, 32'h1);
    w = exp[7:0];
    wr(`SLM_OFF_INSTR, {18'h0, `SLM_OP_SLEEP});
    @(negedge aclk);
    `CHK("osc fetch", 2'h0, {osc, fetch})
    `CHK("wdog", 16'h0, {pres, wcnt})
    `CHK("wclr", 1'h1, wclr)
    `CHK("irq halt", 1'h1, irq)
    rdr(`SLM_OFF_STATUS);
    `CHK("pd to", 3'h6, rd[5:3])
    wr(`SLM_OFF_INSTR, {18'h0, 5'h1e, 1'h0, 8'h55});
    rdr(`SLM_OFF_ACC);
    `CHK("acc asleep", w, rd[7:0])
    @(posedge aclk);
    wake_pin <= 1;
    for (int t = 0; t < 10 && !osc; t++) @(negedge aclk);
    `CHK("woken", 2'h3, {osc, fetch})
    @(posedge aclk);
    wake_pin <= 0;
    rdr(5'h1c);
    `CHK("unmapped", 2'h2, rs)
    wr(5'h09, 32'h000000ff);
    `CHK("unaligned wr", 2'h2, bs)
    rdr(`SLM_OFF_ACC);
    `CHK("acc kept", w, rd[7:0])
    give_verdict();
  end
endmodule // sleep_entry_and_literal_subtract_tb_top
`default_nettype wire
